// ---- design/cpa_defs.svh ----
/*
  Register addresses, field positions, reset values and masks of the
  counter array PWM block.
  Assumes the CPU presents 8-bit special-function-register addresses.
*/
`ifndef CPA_DEFS_SVH
`define CPA_DEFS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define CPA_ADDR_CTRL0 8'hA4
`define CPA_ADDR_STATUS 8'hA5
`define CPA_ADDR_CTRL1 8'hBC
`define CPA_ADDR_CNTL0 8'hA2
`define CPA_ADDR_CNTH0 8'hA3
`define CPA_ADDR_CNTL1 8'hBA
`define CPA_ADDR_CNTH1 8'hBB
`define CPA_ADDR_MODE0 8'hA9
`define CPA_ADDR_MODE1 8'hAA
`define CPA_ADDR_MODE2 8'hAB
`define CPA_ADDR_MODE3 8'hBD
`define CPA_ADDR_MODE4 8'hBE
`define CPA_ADDR_MODE5 8'hBF
`define CPA_ADDR_CMPL0 8'hAC
`define CPA_ADDR_CMPH0 8'hAD
`define CPA_ADDR_CMPL1 8'hAF
`define CPA_ADDR_CMPH1 8'hB1
`define CPA_ADDR_CMPL2 8'hB2
`define CPA_ADDR_CMPH2 8'hB3
`define CPA_ADDR_CMPL3 8'hC1
`define CPA_ADDR_CMPH3 8'hC2
`define CPA_ADDR_CMPL4 8'hC3
`define CPA_ADDR_CMPH4 8'hC4
`define CPA_ADDR_CMPL5 8'hC5
`define CPA_ADDR_CMPH5 8'hC6

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CPA_CTL_ALL 7
`define CPA_CTL_RUN 6
`define CPA_CTL_OVIE 5
`define CPA_CTL_IDLE 4
`define CPA_CTL_W10 2
`define CPA_CTL0_WMASK 8'hF7
`define CPA_CTL1_WMASK 8'h77

// ----------------------------------------------------------------
// Channel mode fields and status bits
// ----------------------------------------------------------------
`define CPA_MODE_EIRQ 7
`define CPA_MODE_ECOMP 6
`define CPA_MODE_MATCH 3
`define CPA_MODE_WIDE 2'b11
`define CPA_STA_BLK0_OVERFLOW 3
`define CPA_STA_BLK1_OVERFLOW 7
`define CPA_RESET_BYTE 8'h00
`define CPA_TEN_MASK 16'h03FF
`define CPA_FULL_MASK 16'hFFFF

`endif

// ---- design/cpa_pkg.sv ----
/*
  Types shared by the counter array PWM design.
  Assumes nothing beyond a SystemVerilog tool.
*/
package cpa_pkg;
  // Counter clock source, in control-field encoding order
  typedef enum logic [1:0] {
    CPA_SRC_PRESC,
    CPA_SRC_T0,
    CPA_SRC_EXT,
    CPA_SRC_NONE
  } cpa_clksrc_t;
  typedef logic [7:0] cpa_byte_t;
endpackage

// ---- design/cpa_channel.sv ----
/*
  One channel module: mode register, compare pair, PWM output and
  match pulse.
  Assumes the parent supplies the already width-masked counter value.
*/
`include "cpa_defs.svh"
module cpa_channel
  import cpa_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic mode_wr, // Write strobe, mode register
  input wire logic lo_wr, // Write strobe, low compare byte
  input wire logic hi_wr, // Write strobe, high compare byte
  input wire cpa_byte_t wdata, // Write data
  input wire logic [15:0] cnt, // Masked counter value
  input wire logic wide10, // Block is in 10-bit width
  input wire logic tick, // Counter advance this cycle
  output cpa_byte_t mode_q, // Mode register
  output cpa_byte_t cmp_lo_q, // Low compare byte
  output cpa_byte_t cmp_hi_q, // High compare byte
  output logic pwm_q, // PWM level
  output logic match_q // One-cycle match pulse
);
  logic [15:0] cmp_v;

  // ----------------------------------------------------------------
  // Mode register with comparator-enable side effects
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= `CPA_RESET_BYTE;
    end else if (mode_wr) begin
      mode_q <= wdata;
    end else if (lo_wr) begin
      mode_q[`CPA_MODE_ECOMP] <= 1'b0;
    end else if (hi_wr) begin
      mode_q[`CPA_MODE_ECOMP] <= 1'b1;
    end
  end

  // Compare bytes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_lo_q <= `CPA_RESET_BYTE;
      cmp_hi_q <= `CPA_RESET_BYTE;
    end else begin
      if (lo_wr) cmp_lo_q <= wdata;
      if (hi_wr) cmp_hi_q <= wdata;
    end
  end

  // Upper six high bits drop out in 10-bit width
  assign cmp_v = wide10 ? ({cmp_hi_q, cmp_lo_q} & `CPA_TEN_MASK)
                        : {cmp_hi_q, cmp_lo_q};

  // ----------------------------------------------------------------
  // PWM level: high from compare to wrap; counter 0 after wrap drops it
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= (mode_q[1:0] == `CPA_MODE_WIDE) && mode_q[`CPA_MODE_ECOMP]
               && (cnt >= cmp_v);
    end
  end

  // Match pulse, only on an advancing count so one event per value
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      match_q <= 1'b0;
    end else begin
      match_q <= tick && mode_q[`CPA_MODE_MATCH] && mode_q[`CPA_MODE_ECOMP]
                 && (cnt == cmp_v);
    end
  end
endmodule // cpa_channel

// ---- design/cpa_top.sv ----
/*
  Counter array PWM top: two counter blocks, six channel modules, the
  control and shared status registers and the CPU interrupt request.
  Assumes a single-cycle SFR write strobe on mclk, prescaler and timer 0
  ticks as one-cycle pulses on mclk, external clock pins asynchronous.
*/
`include "cpa_defs.svh"
module cpa_top
  import cpa_pkg::*;
#(
  parameter int NBLK = 2, // Counter blocks
  parameter int NCH = 3 // Channels per block
) (
  input wire logic mclk, // 25 MHz system clock
  input wire logic arst_n, // Async reset, active low
  input wire cpa_byte_t sfr_addr, // SFR address
  input wire cpa_byte_t sfr_wdata, // SFR write data
  input wire logic sfr_wr, // SFR write strobe, one cycle
  output cpa_byte_t sfr_rdata_q, // Read data, one cycle after address
  input wire logic [NBLK-1:0] presc_tick, // Prescaler output pulses
  input wire logic [NBLK-1:0] t0_ovf, // Timer 0 overflow pulses
  input wire logic [NBLK-1:0] ext_clk, // External counter clock pins
  input wire logic cpu_idle, // CPU is in idle mode
  output logic [NBLK*NCH-1:0] channel_pin_out_q, // PWM pin levels
  output logic [NBLK*NCH-1:0] channel_pin_oe_q, // PWM pin drive enables
  output logic irq_q // Interrupt request to the CPU
);
  localparam int NC = NBLK * NCH;
  localparam logic [5:0][7:0] MODE_ADDR = {`CPA_ADDR_MODE5, `CPA_ADDR_MODE4,
    `CPA_ADDR_MODE3, `CPA_ADDR_MODE2, `CPA_ADDR_MODE1, `CPA_ADDR_MODE0};
  localparam logic [5:0][7:0] LO_ADDR = {`CPA_ADDR_CMPL5, `CPA_ADDR_CMPL4,
    `CPA_ADDR_CMPL3, `CPA_ADDR_CMPL2, `CPA_ADDR_CMPL1, `CPA_ADDR_CMPL0};
  localparam logic [5:0][7:0] HI_ADDR = {`CPA_ADDR_CMPH5, `CPA_ADDR_CMPH4,
    `CPA_ADDR_CMPH3, `CPA_ADDR_CMPH2, `CPA_ADDR_CMPH1, `CPA_ADDR_CMPH0};
  localparam logic [1:0][7:0] CTL_ADDR = {`CPA_ADDR_CTRL1, `CPA_ADDR_CTRL0};
  localparam logic [1:0][7:0] CTL_WMASK = {`CPA_CTL1_WMASK, `CPA_CTL0_WMASK};
  localparam logic [1:0][7:0] CL_ADDR = {`CPA_ADDR_CNTL1, `CPA_ADDR_CNTL0};
  localparam logic [1:0][7:0] CH_ADDR = {`CPA_ADDR_CNTH1, `CPA_ADDR_CNTH0};

  logic [NBLK-1:0][7:0] ctl_q;
  logic [NBLK-1:0][15:0] cnt_q;
  logic [NBLK-1:0][15:0] cnt_eff;
  logic [NBLK-1:0] ext_s1_q, ext_s2_q, ext_s3_q;
  logic [NBLK-1:0] tick, run_eff, ovf_evt, cl_wr, ch_wr;
  logic [NC-1:0][7:0] mode_q, cmp_lo_q, cmp_hi_q;
  logic [NC-1:0] mode_wr, lo_wr, hi_wr, pwm_q, match_q;
  logic [7:0] sta_q, sta_d, hw_set, irq_en;
  logic sta_wr;
  cpa_byte_t rdata_d;

  // ----------------------------------------------------------------
  // External clock pin synchroniser
  // ----------------------------------------------------------------
  // Second and third stages feed the edge detector, the first stays private
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ext_s1_q <= '0;
      ext_s2_q <= '0;
      ext_s3_q <= '0;
    end else begin
      ext_s1_q <= ext_clk;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // Counter blocks
  // ----------------------------------------------------------------
  for (genvar b = 0; b < NBLK; b++) begin : g_blk
    assign cl_wr[b] = sfr_wr && (sfr_addr == CL_ADDR[b]);
    assign ch_wr[b] = sfr_wr && (sfr_addr == CH_ADDR[b]);
    // Start-all in block zero overrides each run bit
    assign run_eff[b] = ctl_q[b][`CPA_CTL_RUN] || ctl_q[0][`CPA_CTL_ALL];
    assign cnt_eff[b] = ctl_q[b][`CPA_CTL_W10] ? (cnt_q[b] & `CPA_TEN_MASK)
                                                : cnt_q[b];

    // Clock select and gating; source 11 never ticks
    always_comb begin
      unique case (cpa_clksrc_t'(ctl_q[b][1:0]))
        CPA_SRC_PRESC: tick[b] = presc_tick[b];
        CPA_SRC_T0: tick[b] = t0_ovf[b];
        CPA_SRC_EXT: tick[b] = ext_s2_q[b] && !ext_s3_q[b];
        CPA_SRC_NONE: tick[b] = 1'b0;
      endcase
      if (!run_eff[b] || (cpu_idle && ctl_q[b][`CPA_CTL_IDLE])) begin
        tick[b] = 1'b0;
      end
    end

    // Overflow when the masked count is at its top value; a same-cycle
    // counter write wins over the tick, so it neither rolls over nor flags
    assign ovf_evt[b] = tick[b] && !cl_wr[b] && !ch_wr[b] && (ctl_q[b][`CPA_CTL_W10]
                        ? (cnt_eff[b] == `CPA_TEN_MASK)
                        : (cnt_eff[b] == `CPA_FULL_MASK));

    // Control register, reserved bit held at zero
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        ctl_q[b] <= `CPA_RESET_BYTE;
      end else if (sfr_wr && (sfr_addr == CTL_ADDR[b])) begin
        ctl_q[b] <= sfr_wdata & CTL_WMASK[b];
      end
    end

    // Counter; software byte writes win over a tick in the same cycle
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        cnt_q[b] <= '0;
      end else if (cl_wr[b] || ch_wr[b]) begin
        if (cl_wr[b]) cnt_q[b][7:0] <= sfr_wdata;
        if (ch_wr[b]) cnt_q[b][15:8] <= sfr_wdata;
      end else if (tick[b]) begin
        if (ctl_q[b][`CPA_CTL_W10]) begin
          cnt_q[b][9:0] <= cnt_q[b][9:0] + 10'd1;
        end else begin
          cnt_q[b] <= cnt_q[b] + 16'd1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel modules
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NC; c++) begin : g_ch
    assign mode_wr[c] = sfr_wr && (sfr_addr == MODE_ADDR[c]);
    assign lo_wr[c] = sfr_wr && (sfr_addr == LO_ADDR[c]);
    assign hi_wr[c] = sfr_wr && (sfr_addr == HI_ADDR[c]);

    cpa_channel cpa_channel_inst (
      .mclk(mclk),
      .arst_n(arst_n),
      .mode_wr(mode_wr[c]),
      .lo_wr(lo_wr[c]),
      .hi_wr(hi_wr[c]),
      .wdata(sfr_wdata),
      .cnt(cnt_eff[c/NCH]),
      .wide10(ctl_q[c/NCH][`CPA_CTL_W10]),
      .tick(tick[c/NCH]),
      .mode_q(mode_q[c]),
      .cmp_lo_q(cmp_lo_q[c]),
      .cmp_hi_q(cmp_hi_q[c]),
      .pwm_q(pwm_q[c]),
      .match_q(match_q[c])
    );
  end

  // Pin level registered once more after pwm_q; drive enable registered straight from the mode, one edge ahead of the level
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      channel_pin_out_q <= '0;
      channel_pin_oe_q <= '0;
    end else begin
      channel_pin_out_q <= pwm_q;
      for (int c = 0; c < NC; c++) begin
        channel_pin_oe_q[c] <= (mode_q[c][1:0] == `CPA_MODE_WIDE);
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared status register and interrupt
  // ----------------------------------------------------------------
  assign sta_wr = sfr_wr && (sfr_addr == `CPA_ADDR_STATUS);
  assign hw_set = {ovf_evt[1], match_q[5:3], ovf_evt[0], match_q[2:0]};
  assign irq_en = {ctl_q[1][`CPA_CTL_OVIE], mode_q[5][`CPA_MODE_EIRQ],
                   mode_q[4][`CPA_MODE_EIRQ], mode_q[3][`CPA_MODE_EIRQ],
                   ctl_q[0][`CPA_CTL_OVIE], mode_q[2][`CPA_MODE_EIRQ],
                   mode_q[1][`CPA_MODE_EIRQ], mode_q[0][`CPA_MODE_EIRQ]};
  // Hardware set wins over a software clear in the same cycle
  assign sta_d = (sta_wr ? sfr_wdata : sta_q) | hw_set;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sta_q <= `CPA_RESET_BYTE;
    end else begin
      sta_q <= sta_d;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(sta_q & irq_en);
    end
  end

  // ----------------------------------------------------------------
  // Read path; unmapped addresses read zero
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = '0;
    if (sfr_addr == `CPA_ADDR_STATUS) rdata_d = sta_q;
    for (int b = 0; b < NBLK; b++) begin
      if (sfr_addr == CTL_ADDR[b]) rdata_d = ctl_q[b];
      if (sfr_addr == CL_ADDR[b]) rdata_d = cnt_q[b][7:0];
      if (sfr_addr == CH_ADDR[b]) rdata_d = cnt_q[b][15:8];
    end
    for (int c = 0; c < NC; c++) begin
      if (sfr_addr == MODE_ADDR[c]) rdata_d = mode_q[c];
      if (sfr_addr == LO_ADDR[c]) rdata_d = cmp_lo_q[c];
      if (sfr_addr == HI_ADDR[c]) rdata_d = cmp_hi_q[c];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata_q <= '0;
    end else begin
      sfr_rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // Status flags: hardware sets them, only a status write clears them
  ovf_flag_set_a: assert property (ovf_evt[0] |=> sta_q[`CPA_STA_BLK0_OVERFLOW])
    else $error("overflow did not set block zero flag");
  block1_overflow_flag_flag_set_a: assert property (ovf_evt[1] |=> sta_q[`CPA_STA_BLK1_OVERFLOW])
    else $error("overflow did not set block one flag");
  evt_flag_hold_a: assert property (sta_q[0] && !sta_wr |=> sta_q[0])
    else $error("event flag dropped without software clear");

  // Comparator enable follows the last compare byte written
  lo_clears_en_a: assert property (lo_wr[0] |=> !mode_q[0][`CPA_MODE_ECOMP])
    else $error("low compare write left comparator enabled");
  hi_sets_en_a: assert property (hi_wr[0] |=> mode_q[0][`CPA_MODE_ECOMP])
    else $error("high compare write left comparator disabled");

  // Pin timing: pwm register, then pin register, so a cause shows two edges later
  ecomp_off_low_a: assert property (!mode_q[0][`CPA_MODE_ECOMP]
    |=> ##1 !channel_pin_out_q[0])
    else $error("pin high with comparator disabled");
  pwm_high_a: assert property ((mode_q[0] == 8'h43)
    && (cnt_eff[0] >= ({cmp_hi_q[0], cmp_lo_q[0]}
    & (ctl_q[0][`CPA_CTL_W10] ? `CPA_TEN_MASK : `CPA_FULL_MASK))) |=> ##1 channel_pin_out_q[0])
    else $error("pin not high at or above compare");
  // The zero count only exists after the overflow edge, hence one edge more
  wrap_low_a: assert property (ovf_evt[0] && !ctl_q[0][`CPA_CTL_W10] && !lo_wr[0]
    && !hi_wr[0] && (cmp_lo_q[0] != 8'h00) |=> ##2 !channel_pin_out_q[0])
    else $error("pin not low after overflow");
  oe_wide_a: assert property ((mode_q[0][1:0] != `CPA_MODE_WIDE)
    |=> !channel_pin_oe_q[0])
    else $error("pin driven outside wide mode");

  // Counter gating and width
  ten_wrap_a: assert property (tick[1] && ctl_q[1][`CPA_CTL_W10] && !cl_wr[1]
    && !ch_wr[1] && (cnt_q[1][9:0] == 10'h3FF) |=> (cnt_eff[1] == 16'h0000))
    else $error("10-bit counter did not wrap");
  idle_halt_a: assert property (cpu_idle && ctl_q[0][`CPA_CTL_IDLE] |-> !tick[0])
    else $error("counter advanced during idle halt");
  run_stop_a: assert property (!ctl_q[0][`CPA_CTL_ALL] && !ctl_q[1][`CPA_CTL_RUN]
    && !cl_wr[1] && !ch_wr[1] |=> $stable(cnt_q[1]))
    else $error("stopped counter moved");
  start_all_a: assert property (ctl_q[0][`CPA_CTL_ALL] && !cpu_idle && t0_ovf[1]
    && (cpa_clksrc_t'(ctl_q[1][1:0]) == CPA_SRC_T0) |-> tick[1])
    else $error("start-all did not run block one");
  reserved_zero_a: assert property (!ctl_q[0][3] && !ctl_q[1][3])
    else $error("reserved control bit set");

  // Interrupt request follows the enabled flags one edge later
  irq_gate_a: assert property (((sta_q & irq_en) == 8'h00) |=> !irq_q)
    else $error("interrupt without an enabled flag");
  irq_raise_a: assert property (((sta_q & irq_en) != 8'h00) |=> irq_q)
    else $error("enabled flag raised no interrupt");

  // Main scenarios a run should reach
  ovf_seen_c: cover property (ovf_evt[0] ##1 sta_q[`CPA_STA_BLK0_OVERFLOW]);
  pwm_rise_c: cover property (!channel_pin_out_q[0] ##1 channel_pin_out_q[0]);
  ten_wrap_c: cover property (ovf_evt[1] && ctl_q[1][`CPA_CTL_W10]);
  irq_c: cover property (!irq_q ##1 irq_q);
  idle_halt_c: cover property (cpu_idle && ctl_q[0][`CPA_CTL_IDLE] && presc_tick[0]);
endmodule // cpa_top

// ---- test/cpa_pin_load.sv ----
/*
  Load model on the six channel pins of the counter array.
  Assumes each pin has a pull-down at the load, so an undriven pin reads low.
*/
module cpa_pin_load (
  input wire logic [5:0] pin_out, // Pin levels from the block
  input wire logic [5:0] pin_oe, // Pin drive enables
  output logic [5:0] pad // Level seen at the load
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-down load: a released pin never shows its last driven level
  assign pad = pin_oe & pin_out;
endmodule // cpa_pin_load

// ---- test/cpa_top_test.sv ----
/*
  Self-checking bench for the counter array PWM top, driven over the SFR bus.
  Assumes the pin load model and a 25 MHz mclk; inputs change 1 ns after edges.
*/
module cpa_top_test
  import cpa_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, arst_n, sfr_wr, cpu_idle, irq_q;
  cpa_byte_t sfr_addr, sfr_wdata, sfr_rdata_q;
  logic [1:0] presc_tick, t0_ovf, ext_clk;
  logic [5:0] pin_out, pin_oe, pad;
  int fails, samples_checked;
  // Compare, counter, expected level
  logic [47:0] tbl[6] = '{48'h1234_1233_0000, 48'h1234_1234_0001, 48'h1234_FFFF_0001,
                          48'h0000_0000_0001, 48'hFFFF_FFFE_0000, 48'hFFFF_FFFF_0001};
  cpa_byte_t adv[4] = '{8'h01, 8'h02, 8'h03, 8'h00};

  cpa_top cpa_top_inst (.mclk(mclk), .arst_n(arst_n), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rdata_q(sfr_rdata_q),
    .presc_tick(presc_tick), .t0_ovf(t0_ovf), .ext_clk(ext_clk), .cpu_idle(cpu_idle),
    .channel_pin_out_q(pin_out), .channel_pin_oe_q(pin_oe), .irq_q(irq_q));
  cpa_pin_load cpa_pin_load_inst (.pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));

  // ----------------------------------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Strobe is lowered a cycle apart so back-to-back writes never collide
  task automatic wr(input cpa_byte_t a, input cpa_byte_t d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
    cyc(1);
  endtask
  // Two edges: wr has already landed its write, the first edge registers the read data, the second holds it
  task automatic rd(input cpa_byte_t a, input cpa_byte_t exp);
    sfr_addr = a;
    cyc(2);
    chk(sfr_rdata_q, exp, "read");
  endtask
  // Low byte goes first, as software must do
  task automatic set16(input cpa_byte_t a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask
  task automatic tk(input int b, input int n);
    repeat (n) begin
      presc_tick[b] = 1'b1;
      cyc(1);
      presc_tick[b] = 1'b0;
      cyc(1);
    end
  endtask
  // One prescaler tick, two timer 0 ticks, three slow external edges
  task automatic burst(input int b);
    presc_tick[b] = 1'b1;
    cyc(1);
    presc_tick[b] = 1'b0;
    repeat (2) begin
      cyc(1);
      t0_ovf[b] = 1'b1;
      cyc(1);
      t0_ovf[b] = 1'b0;
    end
    repeat (3) begin
      cyc(4);
      ext_clk[b] = 1'b1;
      cyc(4);
      ext_clk[b] = 1'b0;
    end
    cyc(6);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // The sequence needs under 2000 cycles; a hang stops at 6000
  initial begin
    repeat (6000) @(posedge mclk);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    presc_tick = 2'b00;
    t0_ovf = 2'b00;
    ext_clk = 2'b00;
    cpu_idle = 1'b0;
    cyc(10);
    arst_n = 1'b1;
    // Reset values, reserved bits, unmapped place
    rd(8'hA4, 8'h00);
    rd(8'hA5, 8'h00);
    rd(8'hBC, 8'h00);
    wr(8'h50, 8'hFF);
    rd(8'h50, 8'h00);
    wr(8'hA4, 8'hFF);
    rd(8'hA4, 8'hF7);
    wr(8'hBC, 8'hFF);
    rd(8'hBC, 8'h77);
    wr(8'hA4, 8'h00);
    wr(8'hBC, 8'h00);
    // Stopped counter against compare, boundary values
    wr(8'hA9, 8'h43);
    foreach (tbl[i]) begin
      set16(8'hAC, tbl[i][47:32]);
      set16(8'hA2, tbl[i][31:16]);
      cyc(3);
      chk(8'(pad[0]), 8'(tbl[i][0]), "pwm level");
    end
    wr(8'hAC, 8'hFF);
    cyc(3);
    chk(8'(pad[0]), 8'h00, "disabled level");
    rd(8'hA9, 8'h03);
    wr(8'hAD, 8'hFF);
    rd(8'hA9, 8'h43);
    chk(8'(pad[0]), 8'h01, "enabled level");
    chk(8'(pin_oe[0]), 8'h01, "drive enable on");
    // Wrap through overflow, then through the match
    wr(8'hA9, 8'h4B);
    set16(8'hAC, 16'h0002);
    set16(8'hA2, 16'hFFFE);
    wr(8'hA4, 8'h40);
    tk(0, 2);
    cyc(2);
    chk(8'(pad[0]), 8'h00, "low after wrap");
    rd(8'hA5, 8'h08);
    tk(0, 3);
    cyc(2);
    chk(8'(pad[0]), 8'h01, "high after compare");
    rd(8'hA5, 8'h09);
    wr(8'hA4, 8'h00);
    rd(8'hA5, 8'h09);
    chk(8'(irq_q), 8'h00, "irq masked");
    wr(8'hA4, 8'h20);
    cyc(2);
    chk(8'(irq_q), 8'h01, "overflow irq");
    wr(8'hA4, 8'h00);
    wr(8'hA9, 8'hCB);
    cyc(2);
    chk(8'(irq_q), 8'h01, "event irq");
    wr(8'hA9, 8'h4B);
    wr(8'hA5, 8'h08);
    rd(8'hA5, 8'h08);
    wr(8'hA5, 8'h00);
    rd(8'hA5, 8'h00);
    wr(8'hA5, 8'h80);
    rd(8'hA5, 8'h80);
    wr(8'hBC, 8'h20);
    cyc(2);
    chk(8'(irq_q), 8'h01, "block one irq");
    wr(8'hBC, 8'h00);
    // Every clock source, counted by distinct numbers of ticks
    foreach (adv[s]) begin
      set16(8'hA2, 16'h0000);
      wr(8'hA4, cpa_byte_t'(8'h40 + s));
      burst(0);
      wr(8'hA4, 8'h00);
      rd(8'hA2, adv[s]);
    end
    // Idle halt, then start-all on block one, whose run bit stays clear
    cpu_idle = 1'b1;
    set16(8'hA2, 16'h0000);
    wr(8'hA4, 8'h50);
    burst(0);
    rd(8'hA2, 8'h00);
    wr(8'hA4, 8'h40);
    burst(0);
    rd(8'hA2, 8'h01);
    wr(8'hA4, 8'h00);
    cpu_idle = 1'b0;
    set16(8'hBA, 16'h0000);
    wr(8'hBC, 8'h01);
    wr(8'hA4, 8'h80);
    burst(1);
    rd(8'hBA, 8'h02);
    wr(8'hA4, 8'h00);
    burst(1);
    rd(8'hBA, 8'h02);
    // Ten-bit width on block one, three channels in PWM mode, only channel 3 checked
    wr(8'hBD, 8'h43);
    wr(8'hBE, 8'h43);
    wr(8'hBF, 8'h43);
    wr(8'hBC, 8'h05);
    set16(8'hC1, 16'hFD00);
    set16(8'hBA, 16'h0200);
    cyc(3);
    chk(8'(pad[3]), 8'h01, "ten-bit compare");
    set16(8'hBA, 16'h07FF);
    wr(8'hA5, 8'h00);
    wr(8'hBC, 8'h45);
    t0_ovf[1] = 1'b1;
    cyc(1);
    t0_ovf[1] = 1'b0;
    cyc(3);
    chk(8'(pad[3]), 8'h00, "ten-bit wrap");
    rd(8'hA5, 8'h80);
    rd(8'hBA, 8'h00);
    wr(8'hBC, 8'h00);
    // Narrow PWM mode does not drive the pin here
    wr(8'hA9, 8'h41);
    set16(8'hAC, 16'h0000);
    cyc(3);
    chk(8'(pad[0]), 8'h00, "pin released");
    chk(8'(pin_oe[0]), 8'h00, "drive enable off");
    stop_test();
  end
endmodule // cpa_top_test
